// ---- design/pclp_params.svh ----
`ifndef PCLP_PARAMS_SVH
`define PCLP_PARAMS_SVH
// Functional notes
// RQ1 - Format 0 pulse+dir, 1 fwd/rev pulses, 2/3/4 quadrature x1/x2/x4
// RQ2 - Formats 5 to 9 repeat formats 0 to 4 with inverted inputs
// RQ3 - Clear input: 0 high, 1 rising, 2 low, 3 falling edge
// RQ4 - Alarm option: 0 alarm or servo off, 1 keep, 2 alarm only
// RQ5 - Input filter: 0 line driver 500 kpps, 1 open collector 200 kpps
// RQ6 - Divided encoder output, 16 to 16384 pulses per revolution, default 1000
// RQ7 - Gear numerator and denominator 1 to 65535, defaults 4 and 1
// RQ8 - First-order command smoothing, 0.01 ms steps up to 6400, zero bypasses
// RQ9 - Gain change follows condition after 1 to 10000 ms, default 100
// RQ10 - Gain switch deviation threshold 1 to 250 command units, default 7 (the code compares it directly with the gear-scaled deviation count)
// RQ11 - Setup word resets to 1011 hex
// RQ12 - Deviation adds scaled command, subtracts feedback, holds until cleared

// ****************************************
// Register offsets
// ****************************************
`define PCLP_OFS_GSD 12'h000
`define PCLP_OFS_GSW 12'h004
`define PCLP_OFS_ISP 12'h008
`define PCLP_OFS_EOD 12'h00C
`define PCLP_OFS_GNUM 12'h010
`define PCLP_OFS_GDEN 12'h014
`define PCLP_OFS_CST 12'h018
`define PCLP_OFS_DEV 12'h01C
`define PCLP_OFS_FPOS 12'h020
`define PCLP_OFS_CTRL 12'h024

// ****************************************
// Reset values and ranges
// ****************************************
`define PCLP_RST_GSD 16'h0064
`define PCLP_RST_GSW 16'h0007
`define PCLP_RST_ISP 16'h1011
`define PCLP_RST_EOD 16'h03E8
`define PCLP_RST_GNUM 16'h0004
`define PCLP_RST_GDEN 16'h0001
`define PCLP_RST_CST 16'h0000
`define PCLP_MAX_GSD 16'h2710
`define PCLP_MAX_GSW 16'h00FA
`define PCLP_MIN_EOD 16'h0010
`define PCLP_MAX_EOD 16'h4000
`define PCLP_MAX_CST 16'h1900

// ****************************************
// Field positions
// ****************************************
`define PCLP_ISP_FMT 3:0
`define PCLP_ISP_CLR 5:4
`define PCLP_ISP_ALM 9:8
`define PCLP_ISP_OC 12

// ****************************************
// Timing
// ****************************************
`define PCLP_CLK_MHZ 100
`define PCLP_SMOOTH_NS 10000
`define PCLP_SMOOTH_CYC (`PCLP_SMOOTH_NS * `PCLP_CLK_MHZ / 1000)
`define PCLP_MS_NS 1000000
`define PCLP_MS_CYC (`PCLP_MS_NS * `PCLP_CLK_MHZ / 1000)
`define PCLP_FILT_LD_NS 200
`define PCLP_FILT_OC_NS 500
`define PCLP_FILT_LD_CYC ((`PCLP_FILT_LD_NS * `PCLP_CLK_MHZ + 999) / 1000)
`define PCLP_FILT_OC_CYC ((`PCLP_FILT_OC_NS * `PCLP_CLK_MHZ + 999) / 1000)
`define PCLP_ENC_COUNTS 32768
`endif

// ---- design/pclp_pkg.sv ----
package pclp_pkg;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pclp_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pclp_apb_rsp_t;

    typedef struct packed {
        logic servo_on;
        logic alarm;
        logic enc_b;
        logic enc_a;
        logic clr;
        logic cmd_b;
        logic cmd_a;
    } pclp_pins_t;

    typedef struct packed {
        logic [15:0] gsd;
        logic [15:0] gsw;
        logic [15:0] isp;
        logic [15:0] eod;
        logic [15:0] gnum;
        logic [15:0] gden;
        logic [15:0] cst;
        logic ctrl;
    } pclp_regs_t;

    typedef struct packed {
        pclp_apb_rsp_t rsp;
        pclp_regs_t regs;
        logic a_prev;
        logic b_prev;
        logic clr_prev;
        logic ea_prev;
        logic eb_prev;
        logic signed [25:0] gear_acc;
        logic signed [31:0] cmd_pos;
        logic signed [31:0] filt_pos;
        logic signed [31:0] sm_acc;
        logic [9:0] tick_cnt;
        logic signed [31:0] dev;
        logic signed [19:0] div_acc;
        logic [1:0] div_q;
        logic div_a;
        logic div_b;
        logic [16:0] ms_cnt;
        logic [13:0] gs_cnt;
        logic gain_alt;
    } pclp_state_t;
endpackage

// ---- design/pclp_pin_filter.sv ----
`timescale 1ns/1ns
`include "pclp_params.svh"
module pclp_pin_filter #(
    parameter int N = 7,
    parameter int CW = 6
) (
    input logic clk_sys,
    input logic reset,
    input logic [N-1:0] pin_raw,
    input logic [N-1:0] long_sel,
    output logic [N-1:0] pin_clean
);
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] q;
        logic [N-1:0][CW-1:0] cnt;
    } pclp_filt_t;

    pclp_filt_t st;
    pclp_filt_t nx;
    logic [CW-1:0] lim;

    // ****************************************
    // Synchroniser and stability filter
    // ****************************************
    always_comb begin
        nx = st;
        lim = '0;
        nx.s1 = pin_raw;
        nx.s2 = st.s1;
        for (int i = 0; i < N; i++) begin
            lim = long_sel[i] ? CW'(`PCLP_FILT_OC_CYC) : CW'(`PCLP_FILT_LD_CYC); // see RQ5
            if (st.s2[i] == st.q[i]) begin
                nx.cnt[i] = '0;
            end else if (st.cnt[i] >= lim - CW'(1)) begin
                nx.q[i] = st.s2[i];
                nx.cnt[i] = '0;
            end else begin
                nx.cnt[i] = st.cnt[i] + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign pin_clean = st.q;
endmodule // pclp_pin_filter

// ---- design/pclp_core.sv ----
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "pclp_params.svh"
module pclp_core #(
    parameter int MS_CYCLES = `PCLP_MS_CYC,
    parameter int ENC_COUNTS = `PCLP_ENC_COUNTS
) (
    input logic clk_sys,
    input logic reset,
    input pclp_pkg::pclp_apb_req_t apb_req,
    output pclp_pkg::pclp_apb_rsp_t apb_rsp,
    input logic cmd_a,
    input logic cmd_b,
    input logic dev_clear_in,
    input logic enc_a,
    input logic enc_b,
    input logic alarm_in,
    input logic servo_on_in,
    output logic div_a,
    output logic div_b,
    output logic gain_alt
);
    import pclp_pkg::*;

    pclp_state_t st;
    pclp_state_t nx;
    pclp_pins_t pins;
    logic [6:0] pins_vec;
    logic [3:0] fmt;
    logic [3:0] base;
    logic inv;
    logic al;
    logic bl;
    logic pal;
    logic pbl;
    logic a_rise;
    logic b_rise;
    logic cup;
    logic cdn;
    logic gup;
    logic gdn;
    logic fup;
    logic fdn;
    logic eup;
    logic edn;
    logic dup;
    logic ddn;
    logic tick;
    logic ms_tick;
    logic dclr;
    logic gs_cond;
    logic acc;
    logic wr_now;
    logic wok;
    logic map;
    logic [31:0] rd;
    logic [1:0] clr_mode;
    logic [1:0] alm_mode;
    logic signed [25:0] gnum_s;
    logic signed [25:0] gden_s;
    logic signed [31:0] cst_s;
    logic signed [31:0] mag;
    logic signed [19:0] eod4;
    logic signed [19:0] cpr;

    // ****************************************
    // Pin conditioning
    // ****************************************
    pclp_pin_filter #(.N(7), .CW(6)) u_filter (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_raw({servo_on_in, alarm_in, enc_b, enc_a, dev_clear_in, cmd_b, cmd_a}),
        .long_sel({4'h0, {3{st.regs.isp[`PCLP_ISP_OC]}}}),
        .pin_clean(pins_vec)
    );
    assign pins = pclp_pins_t'(pins_vec);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nx = st;
        fmt = st.regs.isp[`PCLP_ISP_FMT];
        clr_mode = st.regs.isp[`PCLP_ISP_CLR];
        alm_mode = st.regs.isp[`PCLP_ISP_ALM];
        inv = (fmt >= 4'h5) && (fmt <= 4'h9); // see RQ2
        base = inv ? fmt - 4'h5 : fmt;
        al = pins.cmd_a ^ inv;
        bl = pins.cmd_b ^ inv;
        pal = st.a_prev ^ inv;
        pbl = st.b_prev ^ inv;
        a_rise = al & ~pal;
        b_rise = bl & ~pbl;
        cup = 1'b0;
        cdn = 1'b0;
        // Command decode
        case (base)
            4'h0: begin
                cup = a_rise & ~bl; // see RQ1
                cdn = a_rise & bl;
            end
            4'h1: begin
                cup = a_rise & ~b_rise; // see RQ1
                cdn = b_rise & ~a_rise;
            end
            4'h2: begin
                cup = a_rise & ~bl; // see RQ1
                cdn = a_rise & bl;
            end
            4'h3: begin
                cup = (al ^ pal) & (al ^ bl); // see RQ1
                cdn = (al ^ pal) & ~(al ^ bl);
            end
            4'h4: begin
                cup = ((al ^ pal) ^ (bl ^ pbl)) & (al ^ pbl); // see RQ1
                cdn = ((al ^ pal) ^ (bl ^ pbl)) & ~(al ^ pbl);
            end
            default: begin
                cup = 1'b0;
                cdn = 1'b0;
            end
        endcase
        nx.a_prev = pins.cmd_a;
        nx.b_prev = pins.cmd_b;
        nx.clr_prev = pins.clr;
        nx.ea_prev = pins.enc_a;
        nx.eb_prev = pins.enc_b;

        // Gear scaling
        gnum_s = $signed({10'h000, st.regs.gnum});
        gden_s = $signed({10'h000, st.regs.gden});
        gup = st.gear_acc >= gden_s; // see RQ7
        gdn = !gup && (st.gear_acc <= -gden_s);
        nx.gear_acc = st.gear_acc - (gup ? gden_s : gdn ? -gden_s : 26'sh0)
            + (cup ? gnum_s : cdn ? -gnum_s : 26'sh0);
        nx.cmd_pos = st.cmd_pos + (gup ? 32'sh1 : 32'sh0) - (gdn ? 32'sh1 : 32'sh0);

        // Command smoothing
        tick = st.tick_cnt == 10'(`PCLP_SMOOTH_CYC - 1);
        nx.tick_cnt = tick ? 10'h000 : st.tick_cnt + 10'h001;
        cst_s = $signed({16'h0000, st.regs.cst});
        if (st.regs.cst == 16'h0000) begin
            fup = gup; // see RQ8
            fdn = gdn;
            nx.sm_acc = 32'sh0;
            nx.filt_pos = nx.cmd_pos;
        end else begin
            fup = st.sm_acc >= cst_s; // see RQ8
            fdn = !fup && (st.sm_acc <= -cst_s);
            nx.sm_acc = st.sm_acc - (fup ? cst_s : fdn ? -cst_s : 32'sh0)
                + (tick ? st.cmd_pos - st.filt_pos : 32'sh0);
            nx.filt_pos = st.filt_pos + (fup ? 32'sh1 : 32'sh0) - (fdn ? 32'sh1 : 32'sh0);
        end

        // Feedback decode
        eup = ((pins.enc_a ^ st.ea_prev) ^ (pins.enc_b ^ st.eb_prev))
            & (pins.enc_a ^ st.eb_prev);
        edn = ((pins.enc_a ^ st.ea_prev) ^ (pins.enc_b ^ st.eb_prev))
            & ~(pins.enc_a ^ st.eb_prev);

        // Deviation clear sources
        case (clr_mode)
            2'h0: dclr = pins.clr; // see RQ3
            2'h1: dclr = pins.clr & ~st.clr_prev;
            2'h2: dclr = ~pins.clr;
            default: dclr = ~pins.clr & st.clr_prev;
        endcase
        case (alm_mode)
            2'h0: dclr = dclr | pins.alarm | ~pins.servo_on; // see RQ4
            2'h2: dclr = dclr | pins.alarm;
            default: dclr = dclr;
        endcase

        // Deviation count
        nx.dev = st.dev + (fup ? 32'sh1 : 32'sh0) - (fdn ? 32'sh1 : 32'sh0)
            - (eup ? 32'sh1 : 32'sh0) + (edn ? 32'sh1 : 32'sh0); // see RQ12
        if (dclr) begin
            nx.dev = 32'sh0; // see RQ3
            nx.gear_acc = 26'sh0;
        end

        // Divided encoder output
        eod4 = $signed({2'b00, st.regs.eod, 2'b00});
        cpr = 20'(ENC_COUNTS);
        dup = st.div_acc >= cpr; // see RQ6
        ddn = !dup && (st.div_acc <= -cpr);
        nx.div_acc = st.div_acc - (dup ? cpr : ddn ? -cpr : 20'sh0)
            + (eup ? eod4 : edn ? -eod4 : 20'sh0);
        nx.div_q = st.div_q + (dup ? 2'h1 : 2'h0) - (ddn ? 2'h1 : 2'h0);
        nx.div_a = nx.div_q[0] ^ nx.div_q[1];
        nx.div_b = nx.div_q[1];

        // Automatic gain switch
        mag = st.dev < 0 ? -st.dev : st.dev;
        gs_cond = st.regs.ctrl && (mag <= $signed({16'h0000, st.regs.gsw})); // see RQ10
        ms_tick = {15'h0000, st.ms_cnt} == 32'(MS_CYCLES - 1);
        nx.ms_cnt = ms_tick ? 17'h00000 : st.ms_cnt + 17'h00001;
        if (gs_cond == st.gain_alt) begin
            nx.gs_cnt = 14'h0000;
        end else if (ms_tick) begin
            if ({2'h0, st.gs_cnt} + 16'h0001 >= st.regs.gsd) begin
                nx.gain_alt = gs_cond; // see RQ9
                nx.gs_cnt = 14'h0000;
            end else begin
                nx.gs_cnt = st.gs_cnt + 14'h0001;
            end
        end

        // Register access
        acc = apb_req.psel & apb_req.penable;
        wr_now = acc & st.rsp.pready & apb_req.pwrite & ~st.rsp.pslverr;
        nx.rsp.pready = acc & ~st.rsp.pready;
        rd = 32'h00000000;
        wok = 1'b0;
        map = 1'b1;
        case (apb_req.paddr)
            `PCLP_OFS_GSD: begin
                rd = {16'h0000, st.regs.gsd};
                wok = apb_req.pwdata[15:0] != 16'h0000 && apb_req.pwdata[15:0] <= `PCLP_MAX_GSD;
                if (wr_now) nx.regs.gsd = apb_req.pwdata[15:0];
            end
            `PCLP_OFS_GSW: begin
                rd = {16'h0000, st.regs.gsw};
                wok = apb_req.pwdata[15:0] != 16'h0000 && apb_req.pwdata[15:0] <= `PCLP_MAX_GSW;
                if (wr_now) nx.regs.gsw = apb_req.pwdata[15:0];
            end
            `PCLP_OFS_ISP: begin
                rd = {16'h0000, st.regs.isp};
                wok = 1'b1;
                if (wr_now) nx.regs.isp = apb_req.pwdata[15:0];
            end
            `PCLP_OFS_EOD: begin
                rd = {16'h0000, st.regs.eod};
                wok = apb_req.pwdata[15:0] >= `PCLP_MIN_EOD && apb_req.pwdata[15:0] <= `PCLP_MAX_EOD;
                if (wr_now) nx.regs.eod = apb_req.pwdata[15:0];
            end
            `PCLP_OFS_GNUM: begin
                rd = {16'h0000, st.regs.gnum};
                wok = apb_req.pwdata[15:0] != 16'h0000;
                if (wr_now) nx.regs.gnum = apb_req.pwdata[15:0];
            end
            `PCLP_OFS_GDEN: begin
                rd = {16'h0000, st.regs.gden};
                wok = apb_req.pwdata[15:0] != 16'h0000;
                if (wr_now) nx.regs.gden = apb_req.pwdata[15:0];
            end
            `PCLP_OFS_CST: begin
                rd = {16'h0000, st.regs.cst};
                wok = apb_req.pwdata[15:0] <= `PCLP_MAX_CST;
                if (wr_now) nx.regs.cst = apb_req.pwdata[15:0];
            end
            `PCLP_OFS_DEV: rd = st.dev;
            `PCLP_OFS_FPOS: rd = st.filt_pos;
            `PCLP_OFS_CTRL: begin
                rd = {30'h00000000, st.gain_alt, st.regs.ctrl};
                wok = 1'b1;
                if (wr_now) nx.regs.ctrl = apb_req.pwdata[0];
            end
            default: map = 1'b0;
        endcase
        if (acc & ~st.rsp.pready) begin
            nx.rsp.prdata = rd;
            nx.rsp.pslverr = ~map | (apb_req.pwrite & ~wok);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
            st.regs.gsd <= `PCLP_RST_GSD;
            st.regs.gsw <= `PCLP_RST_GSW;
            st.regs.isp <= `PCLP_RST_ISP; // see RQ11
            st.regs.eod <= `PCLP_RST_EOD;
            st.regs.gnum <= `PCLP_RST_GNUM;
            st.regs.gden <= `PCLP_RST_GDEN;
            st.regs.cst <= `PCLP_RST_CST;
        end else begin
            st <= nx;
        end
    end

    assign apb_rsp = st.rsp;
    assign div_a = st.div_a;
    assign div_b = st.div_b;
    assign gain_alt = st.gain_alt;

    // ****************************************
    // Checks
    // ****************************************
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_access;
        apb_req.psel && apb_req.penable && !st.rsp.pready;
    endsequence
    sequence s_fwd_pulse;
        fmt == 4'h0 && a_rise && !bl && !dclr && st.gear_acc == 26'sh0;
    endsequence
    sequence s_inv_rev;
        fmt == 4'h5 && !pins.cmd_a && st.a_prev && !pins.cmd_b && !dclr
            && st.gear_acc == 26'sh0;
    endsequence

    chk_apb_ready: assert property (s_access |=> st.rsp.pready ##1 !st.rsp.pready)
        else $error("ready not a single cycle after access");
    chk_reset_setup: assert property ($fell(reset) |-> st.regs.isp == `PCLP_RST_ISP) // see RQ11
        else $error("setup word reset value wrong");
    chk_pulse_dir: assert property (s_fwd_pulse |=> st.gear_acc == $past(gnum_s)) // see RQ1
        else $error("forward pulse not scaled forward");
    chk_neg_logic: assert property (s_inv_rev |=> st.gear_acc == -$past(gnum_s)) // see RQ2
        else $error("inverted pulse not decoded");
    chk_clr_level: assert property (clr_mode == 2'h0 && pins.clr |=> st.dev == 32'sh0) // see RQ3
        else $error("level clear missed");
    chk_clr_fall: assert property (clr_mode == 2'h3 && !pins.clr && st.clr_prev
        |=> st.dev == 32'sh0) // see RQ3
        else $error("falling edge clear missed");
    chk_alarm_clear: assert property (alm_mode == 2'h2 && pins.alarm |=> st.dev == 32'sh0) // see RQ4
        else $error("alarm clear missed");
    chk_div_gray: assert property ($changed(st.div_a) |-> $stable(st.div_b)) // see RQ6
        else $error("divided output not quadrature");
    chk_smooth_off: assert property ($past(st.regs.cst) == 16'h0000 && $changed(st.cmd_pos)
        |-> st.filt_pos == st.cmd_pos) // see RQ8
        else $error("bypass did not follow command");
    chk_gain_delay: assert property ($changed(st.gain_alt) |-> $past(ms_tick)) // see RQ9
        else $error("gain changed off the ms tick");
    chk_gain_width: assert property ($rose(st.gain_alt) |-> $past(gs_cond)) // see RQ10
        else $error("gain switched without condition");
    chk_dev_hold: assert property (!dclr && !fup && !fdn && !eup && !edn
        |=> $stable(st.dev)) // see RQ12
        else $error("deviation moved without cause");
endmodule // pclp_core

// ---- tb/pclp_host_model.sv ----
`timescale 1ns/1ns
// ****************************************
// Host command pulse source
// ****************************************
module pclp_host_model (
    input logic clk_sys,
    input logic go,
    input logic [3:0] fmt,
    input logic rev,
    input logic [7:0] n_pulses,
    input logic [7:0] half,
    output logic cmd_a,
    output logic cmd_b,
    output logic busy
);
    logic a = 1'b0;
    logic b = 1'b0;
    logic neg;
    logic one_pin;
    logic [3:0] kind;
    logic [1:0] q = 2'h0;
    assign neg = fmt > 4'h4;
    assign kind = neg ? fmt - 4'h5 : fmt;
    assign one_pin = kind == 4'h1 && rev;
    // Inverted formats idle high
    assign cmd_a = a ^ neg;
    assign cmd_b = b ^ neg;
    initial busy = 1'b0;
    always begin
        @(posedge clk_sys);
        if (go && !busy) begin
            busy <= 1'b1;
            if (kind < 4'h2) begin
                // Direction level settles before the first pulse
                b <= rev && kind == 4'h0;
                repeat (half) @(posedge clk_sys);
                repeat (n_pulses) begin
                    if (one_pin) b <= 1'b1;
                    else a <= 1'b1;
                    repeat (half) @(posedge clk_sys);
                    if (one_pin) b <= 1'b0;
                    else a <= 1'b0;
                    repeat (half) @(posedge clk_sys);
                end
            end else begin
                // A leads B when moving forward
                repeat (4 * n_pulses) begin
                    q = rev ? q - 2'h1 : q + 2'h1;
                    a <= ^q;
                    b <= q[1];
                    repeat (half) @(posedge clk_sys);
                end
            end
            b <= 1'b0;
            busy <= 1'b0;
        end
    end
endmodule // pclp_host_model

// ---- tb/pclp_bench.sv ----
`timescale 1ns/1ns
module pclp_bench;
    import pclp_pkg::*;
    typedef struct packed {
        logic wr;
        logic [11:0] addr;
        logic [15:0] data;
        logic err;
        logic [15:0] rd;
    } pclp_row_t;
    localparam int LIMIT = 80000;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    pclp_apb_req_t req = '0;
    pclp_apb_rsp_t rsp;
    logic clr = 1'b0;
    logic enc_a = 1'b0;
    logic enc_b = 1'b0;
    logic alarm = 1'b0;
    logic servo_on = 1'b1;
    logic go = 1'b0;
    logic rev = 1'b0;
    logic [3:0] fmt = 4'h0;
    logic [7:0] half = 8'h28;
    logic cmd_a, cmd_b, busy, div_a, div_b, gain_alt, e;
    logic [1:0] div_prev = 2'h0;
    logic [31:0] r;
    int div_edges = 0;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    int mult [5] = '{1, 1, 1, 2, 4};
    pclp_row_t rows [26] = '{
        '{1'b0, 12'h000, 16'h0, 1'b0, 16'h64},
        '{1'b0, 12'h004, 16'h0, 1'b0, 16'h7},
        '{1'b0, 12'h008, 16'h0, 1'b0, 16'h1011},
        '{1'b0, 12'h00C, 16'h0, 1'b0, 16'h3E8},
        '{1'b0, 12'h010, 16'h0, 1'b0, 16'h4},
        '{1'b0, 12'h014, 16'h0, 1'b0, 16'h1},
        '{1'b0, 12'h018, 16'h0, 1'b0, 16'h0},
        '{1'b1, 12'h000, 16'h2711, 1'b1, 16'h0},
        '{1'b1, 12'h000, 16'h2710, 1'b0, 16'h0},
        '{1'b0, 12'h000, 16'h0, 1'b0, 16'h2710},
        '{1'b1, 12'h000, 16'h3, 1'b0, 16'h0},
        '{1'b1, 12'h004, 16'h0, 1'b1, 16'h0},
        '{1'b1, 12'h004, 16'hFB, 1'b1, 16'h0},
        '{1'b1, 12'h004, 16'hFA, 1'b0, 16'h0},
        '{1'b1, 12'h00C, 16'hF, 1'b1, 16'h0},
        '{1'b1, 12'h00C, 16'h4001, 1'b1, 16'h0},
        '{1'b1, 12'h00C, 16'h4000, 1'b0, 16'h0},
        '{1'b1, 12'h00C, 16'h10, 1'b0, 16'h0},
        '{1'b0, 12'h00C, 16'h0, 1'b0, 16'h10},
        '{1'b1, 12'h010, 16'h0, 1'b1, 16'h0},
        '{1'b1, 12'h014, 16'h0, 1'b1, 16'h0},
        '{1'b1, 12'h010, 16'h3, 1'b0, 16'h0},
        '{1'b1, 12'h014, 16'h2, 1'b0, 16'h0},
        '{1'b1, 12'h018, 16'h1901, 1'b1, 16'h0},
        '{1'b1, 12'h01C, 16'h5, 1'b1, 16'h0},
        '{1'b0, 12'h028, 16'h0, 1'b1, 16'h0}
    };

    always #5 clk_sys = ~clk_sys;

    pclp_core #(.MS_CYCLES(20), .ENC_COUNTS(256)) pclp_core_inst (
        .clk_sys(clk_sys), .reset(reset), .apb_req(req), .apb_rsp(rsp),
        .cmd_a(cmd_a), .cmd_b(cmd_b), .dev_clear_in(clr), .enc_a(enc_a), .enc_b(enc_b),
        .alarm_in(alarm), .servo_on_in(servo_on), .div_a(div_a), .div_b(div_b),
        .gain_alt(gain_alt)
    );
    pclp_host_model pclp_host_model_inst (
        .clk_sys(clk_sys), .go(go), .fmt(fmt), .rev(rev), .n_pulses(8'h04),
        .half(half), .cmd_a(cmd_a), .cmd_b(cmd_b), .busy(busy)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic close_out();
        $display("compared=%0d mismatches=%0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        if (k == 20) mismatches++;
        e = rsp.pslverr;
        r = rsp.prdata;
        req <= '0;
    endtask
    task automatic dev_is(input int x);
        apb(1'b0, 12'h01C, 32'h0);
        chk(r, 32'(x));
    endtask
    task automatic send(input logic rv, input logic [7:0] hp);
        int k;
        k = 0;
        rev <= rv;
        half <= hp;
        go <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (busy !== 1'b1 && k < 10);
        go <= 1'b0;
        while (busy !== 1'b0 && k < 3000) begin
            @(posedge clk_sys);
            k++;
        end
        waitc(100);
    endtask
    task automatic pulse_clr();
        clr <= 1'b1;
        waitc(80);
        clr <= 1'b0;
        waitc(80);
    endtask
    task automatic pulse_alarm();
        alarm <= 1'b1;
        waitc(80);
        alarm <= 1'b0;
        waitc(80);
    endtask
    task automatic enc_run(input int n);
        logic [1:0] q;
        q = 2'h0;
        repeat (n) begin
            q = q + 2'h1;
            enc_a <= ^q;
            enc_b <= q[1];
            waitc(40);
        end
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        div_prev <= {div_a, div_b};
        if (!reset && div_prev !== {div_a, div_b}) div_edges <= div_edges + 1;
        if (cyc == LIMIT) begin
            mismatches++;
            close_out();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        waitc(5);
        reset <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, {16'h0, rows[i].data});
            chk(32'(e), 32'(rows[i].err));
            if (!rows[i].wr) chk(r, {16'h0, rows[i].rd});
        end
        for (int f = 0; f < 10; f++) begin
            apb(1'b1, 12'h008, 32'h0100 + 32'(f));
            fmt <= 4'(f);
            pulse_clr();
            send(f[0], 8'h28);
            dev_is((f[0] ? -6 : 6) * mult[f % 5]);
        end
        apb(1'b1, 12'h008, 32'h1100);
        fmt <= 4'h0;
        pulse_clr();
        send(1'b0, 8'h23);
        dev_is(0);
        send(1'b0, 8'h46);
        dev_is(6);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 12'h008, 32'h0200 + 32'(m << 4));
            clr <= m > 1;
            waitc(80);
            pulse_alarm();
            dev_is(0);
            send(1'b0, 8'h28);
            dev_is(6);
            clr <= m < 2;
            waitc(80);
            dev_is(0);
            send(1'b0, 8'h28);
            dev_is(m[0] ? 6 : 0);
            clr <= m > 1;
            waitc(80);
        end
        clr <= 1'b0;
        apb(1'b1, 12'h008, 32'h0100);
        pulse_clr();
        send(1'b0, 8'h28);
        pulse_alarm();
        servo_on <= 1'b0;
        waitc(80);
        dev_is(6);
        apb(1'b1, 12'h008, 32'h0000);
        dev_is(0);
        servo_on <= 1'b1;
        waitc(80);
        send(1'b0, 8'h28);
        pulse_alarm();
        dev_is(0);
        enc_run(18);
        waitc(80);
        dev_is(-18);
        chk(32'(div_edges), 32'h4);
        apb(1'b1, 12'h024, 32'h1);
        apb(1'b1, 12'h004, 32'h11);
        waitc(100);
        chk(32'(gain_alt), 32'h0);
        apb(1'b1, 12'h004, 32'h12);
        waitc(25);
        chk(32'(gain_alt), 32'h0);
        waitc(75);
        chk(32'(gain_alt), 32'h1);
        apb(1'b1, 12'h004, 32'h11);
        waitc(25);
        chk(32'(gain_alt), 32'h1);
        waitc(75);
        chk(32'(gain_alt), 32'h0);
        reset <= 1'b1;
        waitc(5);
        reset <= 1'b0;
        apb(1'b0, 12'h008, 32'h0);
        chk(r, 32'h1011);
        dev_is(0);
        // Smoothing from a known tick phase after reset
        apb(1'b1, 12'h018, 32'h3);
        fmt <= 4'h1;
        send(1'b0, 8'h46);
        dev_is(0);
        waitc(500);
        dev_is(5);
        waitc(9000);
        dev_is(16);
        apb(1'b0, 12'h020, 32'h0);
        chk(r, 32'h10);
        close_out();
    end
endmodule // pclp_bench
